// >>> src/pc_seq_params.svh
`ifndef PC_SEQ_PARAMS_SVH
`define PC_SEQ_PARAMS_SVH

// widths
`define PC_WIDTH 13
`define PC_TARGET_WIDTH 11
`define STACK_DEPTH 8
`define STACK_PTR_WIDTH 3
`define DATA_ADDR_WIDTH 9

// field positions in the upper holding register
`define UPPER_LOAD_MSB 4
`define PAGE_BIT_LSB 3
`define PAGE_BIT_MSB 4

// register addresses on the core's file bus
`define ADDR_INDIRECT_PORT 8'h00
`define ADDR_PC_LOW 8'h02
`define ADDR_INDIRECT_PTR 8'h04
`define ADDR_PC_UPPER_HOLD 8'h0a

// reset values
`define PC_RESET 13'h0000
`define UPPER_HOLD_RESET 8'h00
`define PTR_RESET 8'h00
`define SP_RESET 3'h0

`endif

// >>> src/pc_seq_pkg.sv
package pc_seq_pkg;
    typedef enum logic [2:0] {
        PC_OP_STEP,
        PC_OP_HOLD,
        PC_OP_JUMP,
        PC_OP_CALL,
        PC_OP_RETURN,
        PC_OP_INTERRUPT
    } pc_op_t;
endpackage : pc_seq_pkg

// >>> src/ret_stack_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "pc_seq_params.svh"
interface ret_stack_if;
    logic push;
    logic pop;
    logic [`PC_WIDTH-1:0] push_data;
    logic [`PC_WIDTH-1:0] top_data;
    modport owner (output push, output pop, output push_data, input top_data);
    modport store (input push, input pop, input push_data, output top_data);
endinterface : ret_stack_if
`default_nettype wire

// >>> src/ret_stack_mem.sv
`timescale 1ns/1ps
`default_nettype none
`include "pc_seq_params.svh"
module ret_stack_mem
    import pc_seq_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_n_in,
    ret_stack_if.store stk
);
    logic [`PC_WIDTH-1:0] mem_q [`STACK_DEPTH];
    logic [`STACK_PTR_WIDTH-1:0] sp_q;
    logic [`STACK_PTR_WIDTH-1:0] sp_d;
    logic [`STACK_PTR_WIDTH-1:0] top_idx;
    logic [`PC_WIDTH-1:0] top_q;

    // ****************************************
    // circular pointer
    // ****************************************
    // RULE10 wrap no overflow
    assign sp_d = stk.push ? sp_q + 3'h1 : (stk.pop ? sp_q - 3'h1 : sp_q);
    assign top_idx = sp_d - 3'h1;
    assign stk.top_data = top_q;

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            sp_q <= `SP_RESET;
        end else begin
            sp_q <= sp_d;
        end
    end

    // RULE8 eight hidden entries
    always_ff @(posedge mclk_in) begin
        if (stk.push) begin
            mem_q[sp_q] <= stk.push_data;
        end
    end

    // registered top of stack, forwarded on push
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            top_q <= `PC_RESET;
        end else if (stk.push) begin
            top_q <= stk.push_data;
        end else begin
            top_q <= mem_q[top_idx];
        end
    end
endmodule : ret_stack_mem
`default_nettype wire

// >>> src/pc_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "pc_seq_params.svh"
// Overview of operation
// RULE1 - thirteen bit counter, low byte read/write
// RULE2 - high bits only via upper holding
// RULE3 - low byte write loads holding bits 4:0
// RULE4 - jump/call: 11-bit target, page from holding
// RULE5 - call pushes full return address
// RULE6 - returns pop top into whole counter
// RULE7 - interrupt pushes counter like a call
// RULE8 - eight by thirteen hidden stack
// RULE9 - stack ops leave holding untouched
// RULE10 - stack wraps circularly, no overflow flag
// RULE11 - holding bit 4 ignored for paging
// RULE12 - indirect port redirects to pointed register
// RULE13 - indirect read of itself gives zero
// RULE14 - indirect write to itself changes nothing
// RULE15 - nine-bit address: bank bit over pointer
// RULE16 - other instructions advance counter by one
module pc_sequencer
    import pc_seq_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic step_in,
    input wire pc_op_t op_in,
    input wire logic [`PC_TARGET_WIDTH-1:0] target_in,
    input wire logic [`PC_WIDTH-1:0] int_vector_in,
    input wire logic [7:0] file_addr_in,
    input wire logic file_wr_in,
    input wire logic [7:0] file_wdata_in,
    input wire logic [7:0] file_rdata_in,
    input wire logic indirect_bank_bit_in,
    output logic [`PC_WIDTH-1:0] pc_out,
    output logic [7:0] pc_low_byte_out,
    output logic [7:0] pc_upper_holding_out,
    output logic [7:0] indirect_pointer_out,
    output logic [`DATA_ADDR_WIDTH-1:0] data_addr_out,
    output logic data_wr_out,
    output logic [7:0] data_wdata_out,
    output logic [7:0] read_data_out
);
    logic [`PC_WIDTH-1:0] pc_q;
    logic [`PC_WIDTH-1:0] pc_d;
    logic [7:0] upper_q;
    logic [7:0] ptr_q;
    logic [`DATA_ADDR_WIDTH-1:0] daddr_q;
    logic dwr_q;
    logic [7:0] dwdata_q;
    logic [7:0] rdata_q;
    logic [`PC_WIDTH-1:0] pc_inc;
    logic [`PC_WIDTH-1:0] pc_branch;
    logic [`PC_WIDTH-1:0] pc_low_load;
    logic [`PC_WIDTH-1:0] pc_upper_bits;
    logic wr_pc_low;
    logic wr_upper;
    logic wr_ptr;
    logic is_indirect;
    logic ind_self;
    logic [7:0] eff_addr;
    logic [`DATA_ADDR_WIDTH-1:0] data_addr_d;
    logic data_wr_d;
    logic [7:0] read_data_d;
    logic [1:0] page_bits;
    logic do_push;
    logic do_pop;

    ret_stack_if stk ();

    ret_stack_mem u_stack (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .stk(stk)
    );

    // ****************************************
    // register file decode
    // ****************************************
    // RULE12 indirect port redirect
    assign is_indirect = (file_addr_in == `ADDR_INDIRECT_PORT);
    assign eff_addr = is_indirect ? ptr_q : file_addr_in;
    // RULE13 self-access detect
    assign ind_self = is_indirect && (ptr_q == `ADDR_INDIRECT_PORT);
    // RULE14 self write suppressed
    assign wr_pc_low = file_wr_in && !ind_self && (eff_addr == `ADDR_PC_LOW);
    assign wr_upper = file_wr_in && !ind_self && (eff_addr == `ADDR_PC_UPPER_HOLD);
    assign wr_ptr = file_wr_in && !ind_self && (eff_addr == `ADDR_INDIRECT_PTR);
    assign data_wr_d = file_wr_in && !ind_self;
    // RULE15 bank bit over pointer
    assign data_addr_d = {indirect_bank_bit_in, eff_addr};

    // RULE13 self read gives zero
    assign read_data_d = ind_self ? 8'h00 :
                         (eff_addr == `ADDR_PC_LOW) ? pc_q[7:0] :
                         (eff_addr == `ADDR_PC_UPPER_HOLD) ? upper_q :
                         (eff_addr == `ADDR_INDIRECT_PTR) ? ptr_q :
                         file_rdata_in;

    // ****************************************
    // next program counter
    // ****************************************
    // RULE16 advance by one
    assign pc_inc = pc_q + 13'h0001;
    // RULE4 page from holding
    // RULE11 bit 4 ignored
    assign page_bits = {1'b0, upper_q[`PAGE_BIT_LSB]};
    assign pc_branch = {page_bits, target_in};
    // RULE3 holding into high bits
    assign pc_upper_bits = {upper_q[`UPPER_LOAD_MSB:0], 8'h00};
    // RULE2 high bits via holding
    assign pc_low_load = pc_upper_bits | {5'h00, file_wdata_in};

    // RULE5 call pushes return
    // RULE7 interrupt pushes
    assign do_push = step_in && (op_in == PC_OP_CALL || op_in == PC_OP_INTERRUPT);
    // RULE6 returns pop
    assign do_pop = step_in && (op_in == PC_OP_RETURN);
    assign stk.push = do_push;
    assign stk.pop = do_pop;
    assign stk.push_data = (op_in == PC_OP_INTERRUPT) ? pc_q : pc_inc;

    always_comb begin
        pc_d = pc_q;
        if (step_in) begin
            unique case (op_in)
                PC_OP_STEP: pc_d = wr_pc_low ? pc_low_load : pc_inc;
                PC_OP_HOLD: pc_d = pc_q;
                PC_OP_JUMP: pc_d = pc_branch;
                PC_OP_CALL: pc_d = pc_branch;
                PC_OP_RETURN: pc_d = stk.top_data;
                PC_OP_INTERRUPT: pc_d = int_vector_in;
                default: pc_d = pc_q;
            endcase
        end else if (wr_pc_low) begin
            pc_d = pc_low_load;
        end
    end

    // ****************************************
    // state registers
    // ****************************************
    // RULE1 thirteen bit counter
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            pc_q <= `PC_RESET;
        end else begin
            pc_q <= pc_d;
        end
    end

    // RULE9 holding written by software only
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            upper_q <= `UPPER_HOLD_RESET;
        end else if (wr_upper) begin
            upper_q <= file_wdata_in;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            ptr_q <= `PTR_RESET;
        end else if (wr_ptr) begin
            ptr_q <= file_wdata_in;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            daddr_q <= 9'h000;
            dwr_q <= 1'b0;
            dwdata_q <= 8'h00;
            rdata_q <= 8'h00;
        end else begin
            daddr_q <= data_addr_d;
            dwr_q <= data_wr_d;
            dwdata_q <= file_wdata_in;
            rdata_q <= read_data_d;
        end
    end

    assign pc_out = pc_q;
    assign pc_low_byte_out = pc_q[7:0];
    assign pc_upper_holding_out = upper_q;
    assign indirect_pointer_out = ptr_q;
    assign data_addr_out = daddr_q;
    assign data_wr_out = dwr_q;
    assign data_wdata_out = dwdata_q;
    assign read_data_out = rdata_q;
endmodule : pc_sequencer
`default_nettype wire

// >>> bench/pc_seq_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "pc_seq_params.svh"
module pc_seq_sva
    import pc_seq_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic step_in,
    input wire pc_op_t op_in,
    input wire logic [10:0] target_in,
    input wire logic [12:0] int_vector_in,
    input wire logic [7:0] file_addr_in,
    input wire logic file_wr_in,
    input wire logic [7:0] file_wdata_in,
    input wire logic indirect_bank_bit_in,
    input wire logic [12:0] pc_out,
    input wire logic [7:0] pc_upper_holding_out,
    input wire logic [7:0] indirect_pointer_out,
    input wire logic [8:0] data_addr_out,
    input wire logic data_wr_out,
    input wire logic [7:0] read_data_out
);
    // ***
    // counter, stack and indirect access checks
    // ***
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_n_in);
    sequence s_call;
        step_in && op_in == PC_OP_CALL;
    endsequence
    sequence s_ret;
        step_in && op_in == PC_OP_RETURN;
    endsequence
    a_step_adds_one: assert property (step_in && op_in == PC_OP_STEP && !file_wr_in
        |=> pc_out == $past(pc_out) + 13'h0001) else $error("step did not add one");
    a_jump_page_bits: assert property (step_in && op_in == PC_OP_JUMP
        |=> pc_out == {1'b0, $past(pc_upper_holding_out[3]), $past(target_in)})
        else $error("jump target wrong");
    a_call_ret_pair: assert property (s_call ##1 s_ret
        |=> pc_out == $past(pc_out, 2) + 13'h0001) else $error("return address wrong");
    a_irq_vector: assert property (step_in && op_in == PC_OP_INTERRUPT
        |=> pc_out == $past(int_vector_in)) else $error("interrupt vector wrong");
    a_low_write_load: assert property (file_wr_in && file_addr_in == `ADDR_PC_LOW && !step_in
        |=> pc_out == {$past(pc_upper_holding_out[4:0]), $past(file_wdata_in)})
        else $error("low byte load wrong");
    a_stack_keeps_hold: assert property ((s_call or s_ret) and !file_wr_in
        |=> $stable(pc_upper_holding_out)) else $error("holding changed");
    a_self_write_drop: assert property (file_wr_in && file_addr_in == 8'h00
        && indirect_pointer_out == 8'h00 |=> !data_wr_out) else $error("self write passed");
    a_indirect_addr: assert property (file_addr_in == 8'h00
        |=> data_addr_out == {$past(indirect_bank_bit_in), $past(indirect_pointer_out)})
        else $error("indirect address wrong");
    a_self_read_zero: assert property (file_addr_in == 8'h00 && !file_wr_in
        && indirect_pointer_out == 8'h00 |=> read_data_out == 8'h00) else $error("self read");
endmodule : pc_seq_sva
bind pc_sequencer pc_seq_sva i_sva (.*);
`default_nettype wire

// >>> bench/ext_regs.sv
`timescale 1ns/1ps
`default_nettype none
module ext_regs (
    input wire logic mclk_in,
    input wire logic [7:0] file_addr_in,
    input wire logic [7:0] indirect_pointer_out,
    input wire logic [8:0] data_addr_out,
    input wire logic data_wr_out,
    input wire logic [7:0] data_wdata_out,
    output logic [7:0] file_rdata_in
);
    // ***
    // outside data registers
    // ***
    logic [7:0] mem_q [0:255];
    wire logic [7:0] eff_addr = (file_addr_in == 8'h00) ? indirect_pointer_out : file_addr_in;
    assign file_rdata_in = mem_q[eff_addr];
    always_ff @(posedge mclk_in) begin
        if (data_wr_out) begin
            mem_q[data_addr_out[7:0]] <= data_wdata_out;
        end
    end
endmodule : ext_regs
`default_nettype wire

// >>> bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pc_seq_params.svh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin n_mismatch++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb
    import pc_seq_pkg::*;
;
    // ***
    // stimulus and checks
    // ***
    logic mclk_in, rst_n_in, step_in, file_wr_in, indirect_bank_bit_in, data_wr_out;
    pc_op_t op_in;
    logic [10:0] target_in;
    logic [12:0] int_vector_in, pc_out, e_pc;
    logic [12:0] rets [0:8];
    logic [7:0] file_addr_in, file_wdata_in, file_rdata_in, pc_low_byte_out;
    logic [7:0] pc_upper_holding_out, indirect_pointer_out, data_wdata_out, read_data_out;
    logic [8:0] data_addr_out;
    int checks, n_mismatch;
    pc_sequencer i_dut (.*);
    ext_regs i_regs (.*);
    initial begin
        mclk_in = 0;
        forever #12.5 mclk_in = ~mclk_in;
    end
    task op(input pc_op_t o, input logic [10:0] t);
        step_in = 1;
        op_in = o;
        target_in = t;
        @(negedge mclk_in);
    endtask : op
    task wr(input logic [7:0] a, input logic [7:0] d);
        file_addr_in = a;
        file_wr_in = 1;
        file_wdata_in = d;
        @(negedge mclk_in);
    endtask : wr
    task idle;
        step_in = 0;
        file_wr_in = 0;
        @(negedge mclk_in);
    endtask : idle
    task rd(input logic [7:0] a);
        file_addr_in = a;
        repeat (2) @(negedge mclk_in);
    endtask : rd
    task t_wrap;
        op(PC_OP_JUMP, 11'h040);
        e_pc = 13'h0040;
        for (int k = 0; k < 9; k++) begin
            rets[k] = e_pc + 13'h0001;
            op(PC_OP_CALL, 11'h100 + 11'(k));
            e_pc = 13'h0100 + 13'(k);
            `CHK("call pc", e_pc, pc_out)
        end
        for (int k = 8; k > 0; k--) begin
            op(PC_OP_RETURN, 11'h000);
            `CHK("ret pc", rets[k], pc_out)
        end
        op(PC_OP_RETURN, 11'h000);
        `CHK("wrap pc", rets[8], pc_out)
        idle;
    endtask : t_wrap
    task t_branch;
        wr(`ADDR_PC_UPPER_HOLD, 8'h18);
        idle;
        `CHK("hold write", 13'h0108, pc_out)
        op(PC_OP_JUMP, 11'h123);
        `CHK("jump pc", 13'h0923, pc_out)
        op(PC_OP_CALL, 11'h055);
        op(PC_OP_INTERRUPT, 11'h000);
        `CHK("irq pc", 13'h0004, pc_out)
        op(PC_OP_RETURN, 11'h000);
        `CHK("reti pc", 13'h0855, pc_out)
        op(PC_OP_RETURN, 11'h000);
        op(PC_OP_STEP, 11'h000);
        `CHK("step pc", 13'h0925, pc_out)
        op(PC_OP_HOLD, 11'h000);
        `CHK("hold pc", 13'h0925, pc_out)
        idle;
        `CHK("holding", 8'h18, pc_upper_holding_out)
    endtask : t_branch
    task t_low;
        wr(`ADDR_PC_UPPER_HOLD, 8'h1f);
        wr(`ADDR_PC_LOW, 8'h34);
        idle;
        `CHK("low load", 13'h1f34, pc_out)
        `CHK("low byte", 8'h34, pc_low_byte_out)
        rd(`ADDR_PC_LOW);
        `CHK("low read", 8'h34, read_data_out)
    endtask : t_low
    task t_ind;
        wr(`ADDR_INDIRECT_PTR, 8'h05);
        wr(`ADDR_INDIRECT_PORT, 8'h10);
        idle;
        rd(`ADDR_INDIRECT_PORT);
        `CHK("ind read", 8'h10, read_data_out)
        `CHK("ind addr", 9'h105, data_addr_out)
        wr(`ADDR_INDIRECT_PTR, 8'h00);
        wr(`ADDR_INDIRECT_PORT, 8'h77);
        idle;
        rd(`ADDR_INDIRECT_PORT);
        `CHK("self read", 8'h00, read_data_out)
        wr(`ADDR_INDIRECT_PTR, 8'h05);
        idle;
        rd(`ADDR_INDIRECT_PORT);
        `CHK("self write", 8'h10, read_data_out)
    endtask : t_ind
    task test_done;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : test_done
    initial begin
        #(25 * 3000);
        n_mismatch++;
        test_done;
    end
    initial begin
        {rst_n_in, step_in, file_wr_in, target_in, file_addr_in, file_wdata_in} = '0;
        op_in = PC_OP_STEP;
        indirect_bank_bit_in = 1;
        int_vector_in = 13'h0004;
        repeat (12) @(negedge mclk_in);
        `CHK("reset pc", 13'h0000, pc_out)
        `CHK("reset ptr", 8'h00, indirect_pointer_out)
        rst_n_in = 1;
        @(negedge mclk_in);
        t_wrap;
        t_branch;
        t_low;
        t_ind;
        test_done;
    end
endmodule : tb
`default_nettype wire
